// [rtl/tsr_pkg.sv]
// package for the trap sequencing block: constants, enums and carriers
package tsr_pkg;
	localparam int        PSW_TRACE_BIT   = 4;        // trace flag position in status word
	localparam logic [15:0] STACK_LIMIT   = 16'h0100; // fixed stack limit (400 octal)
	localparam logic [15:0] VEC_PSW_OFS   = 16'h0002; // saved status word sits at vector + 2
	localparam logic [15:0] PSW_RST       = 16'h0000;
	localparam logic [15:0] VEC_OVERFLOW  = 16'h0004; // stack overflow vector
	localparam logic [15:0] VEC_TRACE     = 16'h000c; // trace trap vector
	localparam logic [2:0]  MODE_AUTOINC  = 3'h2;
	localparam logic [2:0]  MODE_AUTODEC  = 3'h4;
	localparam logic [2:0]  MODE_AUTODECD = 3'h5;
	localparam logic [3:0]  SP_REG        = 4'h6;

	// source of a status word load
	typedef enum logic [2:0] {
		PSW_SRC_NONE = 3'b000,
		PSW_SRC_RTI  = 3'b001,
		PSW_SRC_RTT  = 3'b010,
		PSW_SRC_TRAP = 3'b011,
		PSW_SRC_INTR = 3'b100,
		PSW_SRC_BUS  = 3'b101,
		PSW_SRC_CONS = 3'b110
	} tsr_psw_src_e;

	// winner of boundary arbitration, highest first
	typedef enum logic [2:0] {
		EV_NONE  = 3'b000,
		EV_HALT  = 3'b001,
		EV_BUSER = 3'b010,
		EV_MMU   = 3'b011,
		EV_TRAPI = 3'b100,
		EV_TRACE = 3'b101,
		EV_STKOV = 3'b110,
		EV_INTR  = 3'b111
	} tsr_event_e;

	// pending requests seen at an instruction boundary
	typedef struct packed {
		logic halt;
		logic bus_err;
		logic mmu_err;
		logic trap_insn;
		logic trace;
		logic stack_ovf;
		logic intr;
	} tsr_req_s;

	// addressing information of the operand that faulted
	typedef struct packed {
		logic [2:0] mode;
		logic       is_move;
		logic       is_dest;
		logic       is_mtp;
	} tsr_opnd_s;

	// status word load request
	typedef struct packed {
		tsr_psw_src_e src;
		logic [15:0]  data;
	} tsr_psw_wr_s;
endpackage : tsr_pkg

// [rtl/tsr_prio.sv]
// fixed priority arbiter for traps and interrupts at an instruction boundary
module tsr_prio
	import tsr_pkg::*;
(
	// requests
	input  wire tsr_req_s   req_in,
	// winner
	output tsr_event_e      win_out
);
	// highest priority request wins
	always_comb begin
		if (req_in.halt)           win_out = EV_HALT;  // RL9
		else if (req_in.bus_err)   win_out = EV_BUSER;
		else if (req_in.mmu_err)   win_out = EV_MMU;
		else if (req_in.trap_insn) win_out = EV_TRAPI;
		else if (req_in.trace)     win_out = EV_TRACE;
		else if (req_in.stack_ovf) win_out = EV_STKOV;
		else if (req_in.intr)      win_out = EV_INTR;
		else                       win_out = EV_NONE;
	end
endmodule : tsr_prio

// [rtl/tsr_core.sv]
// trap sequencing core: trace flag, bus error increment, preemption, mid-trap status
// Overview of operation
// RL1: trace flag loads only from return ops, trap and interrupt sequences.
// RL2: odd address in mode 2 leaves register unchanged, except move and mtp.
// RL3: nonexistent memory in mode 2: no increment, except move destination and mtp.
// RL4: pending higher interrupt preempts a service routine's first instruction.
// RL5: management fault between trap pushes saves vector plus 2 contents as status.
// RL6: trace set by interrupt return traps right after that instruction.
// RL7: after trap return, next instruction runs before trace trap is taken.
// RL8: fixed stack limit checked after modes 4, 5, calls, traps; no red zone.
// RL9: simultaneous requests resolved by fixed priority at each boundary.
module tsr_core
	import tsr_pkg::*;
(
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        sys_rst_in,
	// status word load requests
	input  wire tsr_psw_wr_s psw_wr_in,
	// instruction boundary and pending requests
	input  wire logic        boundary_in,
	input  wire tsr_req_s    req_in,
	input  wire logic [2:0]  intr_prio_in,
	input  wire logic        isr_entry_in,
	// operand fault report
	input  wire logic        odd_err_in,
	input  wire logic        nxm_err_in,
	input  wire tsr_opnd_s   opnd_in,
	// stack pointer check
	input  wire logic        sp_update_in,
	input  wire logic [15:0] sp_in,
	input  wire logic [2:0]  sp_mode_in,
	input  wire logic        call_or_trap_in,
	// trap sequence pushes
	input  wire logic        push1_done_in,
	input  wire logic        push2_done_in,
	input  wire logic        mmu_viol_in,
	input  wire logic [15:0] vec_word_in,
	// outputs
	output logic [15:0]      psw_out,
	output logic             reg_inc_out,
	output logic             fault_ack_out,
	output tsr_event_e       take_out,
	output logic             stack_ovf_out,
	output logic [15:0]      saved_psw_out,
	output logic             saved_valid_out,
	output logic             isr_hold_out
);
	// all state in one struct
	typedef struct packed {
		logic [15:0] psw;
		logic        reg_inc;
		logic        fault_ack;
		tsr_event_e  take;
		logic        stk_pend;
		logic        trace_pend;
		logic        rtt_skip;
		logic        in_trap;
		logic        mid_push;
		logic [15:0] saved_psw;
		logic        saved_valid;
		logic        isr_hold;
		logic [2:0]  cur_prio;
	} tsr_state_s;

	tsr_state_s st_r;
	tsr_state_s st_nxt;
	tsr_req_s   req_eff;
	tsr_event_e win;

	// true when the source may load the trace flag
	function automatic logic trace_src_ok(input tsr_psw_src_e s);
		return (s == PSW_SRC_RTI) || (s == PSW_SRC_RTT) ||
			(s == PSW_SRC_TRAP) || (s == PSW_SRC_INTR);
	endfunction : trace_src_ok

	// merge internal pending trace and overflow into arbitration
	always_comb begin
		req_eff           = req_in;
		req_eff.trace     = req_in.trace | (st_r.trace_pend & ~st_r.rtt_skip);
		req_eff.stack_ovf = req_in.stack_ovf | st_r.stk_pend;
	end

	tsr_prio u_prio (
		.req_in  (req_eff),
		.win_out (win)
	);

	// next state
	always_comb begin
		st_nxt           = st_r;
		st_nxt.fault_ack = 1'b0;
		st_nxt.take      = EV_NONE;
		// boundary arbitration first, so a set further down in the same cycle beats a clear
		if (boundary_in) begin
			st_nxt.take = win; // RL9
			if (st_r.rtt_skip)
				st_nxt.rtt_skip = 1'b0; // RL7
			unique case (win)
				EV_TRACE: st_nxt.trace_pend = 1'b0;
				EV_STKOV: st_nxt.stk_pend   = 1'b0;
				default:  st_nxt.take       = win;
			endcase
		end
		// status word load, trace flag filtered by source
		if (psw_wr_in.src != PSW_SRC_NONE) begin
			st_nxt.psw = psw_wr_in.data;
			if (!trace_src_ok(psw_wr_in.src))
				st_nxt.psw[PSW_TRACE_BIT] = st_r.psw[PSW_TRACE_BIT]; // RL1
			if (psw_wr_in.src == PSW_SRC_RTI && psw_wr_in.data[PSW_TRACE_BIT]) begin
				st_nxt.trace_pend = 1'b1; // RL6
				st_nxt.rtt_skip   = 1'b0;
			end
			if (psw_wr_in.src == PSW_SRC_RTT && psw_wr_in.data[PSW_TRACE_BIT]) begin
				st_nxt.trace_pend = 1'b1;
				st_nxt.rtt_skip   = 1'b1; // RL7
			end
		end
		// bus error on an operand, increment only in autoincrement mode
		if (odd_err_in || nxm_err_in) begin
			st_nxt.fault_ack = 1'b1;
			if (opnd_in.mode != MODE_AUTOINC)
				st_nxt.reg_inc = 1'b0;
			else if (opnd_in.is_mtp)
				st_nxt.reg_inc = 1'b1; // RL2 RL3
			else if (odd_err_in)
				st_nxt.reg_inc = opnd_in.is_move; // RL2
			else
				st_nxt.reg_inc = opnd_in.is_move & opnd_in.is_dest; // RL3
		end
		// stack limit check
		if (sp_update_in && (sp_in < STACK_LIMIT) &&
			(sp_mode_in == MODE_AUTODEC || sp_mode_in == MODE_AUTODECD || call_or_trap_in))
			st_nxt.stk_pend = 1'b1; // RL8
		// trap sequence pushes and mid-trap management fault
		if (push1_done_in)
			st_nxt.mid_push = 1'b1;
		if (push2_done_in)
			st_nxt.mid_push = 1'b0;
		if (st_r.mid_push && mmu_viol_in) begin
			st_nxt.saved_psw   = vec_word_in; // RL5
			st_nxt.saved_valid = 1'b1;
			st_nxt.mid_push    = 1'b0;
		end else if (push2_done_in) begin
			st_nxt.saved_valid = 1'b0;
		end
		// service routine entry: hold first instruction if higher interrupt waits
		if (isr_entry_in)
			st_nxt.cur_prio = intr_prio_in;
		st_nxt.isr_hold = isr_entry_in && req_in.intr && (intr_prio_in > st_r.cur_prio); // RL4
	end

	// state register
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs from state flops
	assign psw_out         = st_r.psw;
	assign reg_inc_out     = st_r.reg_inc;
	assign fault_ack_out   = st_r.fault_ack;
	assign take_out        = st_r.take;
	assign stack_ovf_out   = st_r.stk_pend;
	assign saved_psw_out   = st_r.saved_psw;
	assign saved_valid_out = st_r.saved_valid;
	assign isr_hold_out    = st_r.isr_hold;

	AST_TRACE_SRC: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RL1
		(psw_wr_in.src == PSW_SRC_BUS || psw_wr_in.src == PSW_SRC_CONS)
		|=> $stable(psw_out[PSW_TRACE_BIT]))
		else $error("trace flag loaded by a forbidden source");
	AST_ODD_INC: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RL2
		odd_err_in && opnd_in.mode == MODE_AUTOINC && !opnd_in.is_move && !opnd_in.is_mtp
		|=> !reg_inc_out && fault_ack_out)
		else $error("register incremented after odd address");
	AST_NXM_INC: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RL3
		nxm_err_in && !odd_err_in && opnd_in.mode == MODE_AUTOINC
		|=> reg_inc_out == $past(opnd_in.is_mtp | (opnd_in.is_move & opnd_in.is_dest)))
		else $error("wrong increment after nonexistent memory");
	AST_ISR_HOLD: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RL4
		isr_entry_in && req_in.intr && intr_prio_in > st_r.cur_prio |=> isr_hold_out)
		else $error("first instruction not held for higher interrupt");
	AST_MID_PUSH: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RL5
		st_r.mid_push && mmu_viol_in |=> saved_valid_out && saved_psw_out == $past(vec_word_in))
		else $error("mid-trap status word not taken from vector plus 2");
	AST_RTI_TRACE: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RL6
		psw_wr_in.src == PSW_SRC_RTI && psw_wr_in.data[PSW_TRACE_BIT]
		##1 boundary_in && !req_in.halt && !req_in.bus_err && !req_in.mmu_err
		&& !req_in.trap_insn |=> take_out == EV_TRACE)
		else $error("trace not taken right after interrupt return");
	AST_RTT_SKIP: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RL7
		psw_wr_in.src == PSW_SRC_RTT && psw_wr_in.data[PSW_TRACE_BIT]
		##1 boundary_in && !req_in.trace |=> take_out != EV_TRACE)
		else $error("trace taken before next instruction after trap return");
	AST_STACK_OVF: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RL8
		sp_update_in && sp_in < STACK_LIMIT && call_or_trap_in |=> stack_ovf_out)
		else $error("stack overflow not flagged");
	AST_PRIO: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RL9
		boundary_in && req_in.halt |=> take_out == EV_HALT)
		else $error("halt lost arbitration");

	// further checks on the fault, stack and trace paths
	AST_MTP_INC: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RL3
		(odd_err_in || nxm_err_in) && opnd_in.mode == MODE_AUTOINC && opnd_in.is_mtp
		|=> reg_inc_out)
		else $error("register not incremented for previous space move");
	AST_MODE_INC: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RL2
		(odd_err_in || nxm_err_in) && opnd_in.mode != MODE_AUTOINC |=> !reg_inc_out)
		else $error("register incremented outside autoincrement mode");
	AST_STACK_MODE: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RL8
		sp_update_in && sp_in < STACK_LIMIT
		&& (sp_mode_in == MODE_AUTODEC || sp_mode_in == MODE_AUTODECD) |=> stack_ovf_out)
		else $error("stack overflow after autodecrement not flagged");
	AST_STACK_OK: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RL8
		sp_update_in && sp_in >= STACK_LIMIT && !stack_ovf_out |=> !stack_ovf_out)
		else $error("stack overflow flagged at or above the limit");
	AST_TRACE_LOAD: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RL1
		psw_wr_in.src inside {PSW_SRC_RTI, PSW_SRC_RTT, PSW_SRC_TRAP, PSW_SRC_INTR}
		|=> psw_out[PSW_TRACE_BIT] == $past(psw_wr_in.data[PSW_TRACE_BIT]))
		else $error("trace flag not loaded by a permitted source");
endmodule : tsr_core

// [verif/tb.sv]
// self-checking testbench for the trap sequencing core
module tb
	import tsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// one pending expectation: cycle due, output selector, value
	typedef struct {
		int          due;
		int          sel;
		logic [15:0] exp;
	} tsr_note_s;

	logic        mclk_in    = 1'b0;
	logic        sys_rst_in = 1'b1;
	tsr_psw_wr_s psw_wr_in;
	logic        boundary_in;
	tsr_req_s    req_in;
	logic [2:0]  intr_prio_in;
	logic        isr_entry_in;
	logic        odd_err_in;
	logic        nxm_err_in;
	tsr_opnd_s   opnd_in;
	logic        sp_update_in;
	logic [15:0] sp_in;
	logic [2:0]  sp_mode_in;
	logic        call_or_trap_in;
	logic        push1_done_in;
	logic        push2_done_in;
	logic        mmu_viol_in;
	logic [15:0] vec_word_in;
	logic [15:0] psw_out;
	logic        reg_inc_out;
	logic        fault_ack_out;
	tsr_event_e  take_out;
	logic        stack_ovf_out;
	logic [15:0] saved_psw_out;
	logic        saved_valid_out;
	logic        isr_hold_out;
	int          cyc      = 0;
	int          n_fail   = 0;
	int          n_checks = 0;
	integer      seed     = 32'h7739c41b;
	tsr_note_s   notes[$];
	string       nm[8]    = '{"psw", "reg_inc", "fault_ack", "take", "stack_ovf",
		"saved_psw", "saved_valid", "isr_hold"};

	tsr_core uut (.mclk_in, .sys_rst_in, .psw_wr_in, .boundary_in, .req_in, .intr_prio_in,
		.isr_entry_in, .odd_err_in, .nxm_err_in, .opnd_in, .sp_update_in, .sp_in,
		.sp_mode_in, .call_or_trap_in, .push1_done_in, .push2_done_in, .mmu_viol_in,
		.vec_word_in, .psw_out, .reg_inc_out, .fault_ack_out, .take_out, .stack_ovf_out,
		.saved_psw_out, .saved_valid_out, .isr_hold_out);

	// 40 MHz clock
	always #12.5 mclk_in = ~mclk_in;

	// cycle count and hang guard
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			finish_test();
		end
	end

	function automatic logic [15:0] seen(input int sel);
		case (sel)
			0: return psw_out;
			1: return {15'h0000, reg_inc_out};
			2: return {15'h0000, fault_ack_out};
			3: return {13'h0000, take_out};
			4: return {15'h0000, stack_ovf_out};
			5: return saved_psw_out;
			6: return {15'h0000, saved_valid_out};
			default: return {15'h0000, isr_hold_out};
		endcase
	endfunction : seen

	task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// watcher: compare the oldest note once its result is due
	always @(negedge mclk_in) begin
		while (notes.size() > 0 && notes[0].due <= cyc) begin
			check(nm[notes[0].sel], seen(notes[0].sel), notes[0].exp);
			void'(notes.pop_front());
		end
	end

	task automatic want(input int sel, input logic [15:0] v);
		notes.push_back('{cyc + 1, sel, v});
	endtask : want

	// all inputs back to idle
	task automatic z();
		psw_wr_in = '{PSW_SRC_NONE, 16'h0000};
		{boundary_in, isr_entry_in, odd_err_in, nxm_err_in, sp_update_in} = 5'h00;
		{push1_done_in, push2_done_in, mmu_viol_in, call_or_trap_in} = 4'h0;
		req_in = '0;
		opnd_in = '0;
		{intr_prio_in, sp_mode_in, sp_in, vec_word_in} = 38'h0;
	endtask : z

	task automatic clr();
		@(negedge mclk_in);
		z();
	endtask : clr

	task automatic rst(input int n);
		@(negedge mclk_in);
		sys_rst_in = 1'b1;
		repeat (n) @(negedge mclk_in);
		sys_rst_in = 1'b0;
	endtask : rst

	task automatic wr(input tsr_psw_src_e s, input logic [15:0] d, input logic [15:0] e);
		@(negedge mclk_in);
		psw_wr_in = '{s, d};
		want(0, e);
		clr();
	endtask : wr

	// status load followed by an instruction boundary in the very next cycle
	task automatic wrb(input tsr_psw_src_e s, input logic [15:0] d, input tsr_event_e e);
		@(negedge mclk_in);
		psw_wr_in = '{s, d};
		want(0, d);
		@(negedge mclk_in);
		z();
		boundary_in = 1'b1;
		want(3, 16'(e));
		clr();
	endtask : wrb

	task automatic bnd(input tsr_req_s r, input tsr_event_e e);
		@(negedge mclk_in);
		req_in = r;
		intr_prio_in = 3'h7;
		boundary_in = 1'b1;
		want(3, 16'(e));
		clr();
	endtask : bnd

	task automatic spc(input logic [2:0] m, input logic [15:0] s, input logic c, input logic e);
		@(negedge mclk_in);
		{sp_update_in, sp_mode_in, sp_in, call_or_trap_in} = {1'b1, m, s, c};
		want(4, {15'h0000, e});
		clr();
	endtask : spc

	function automatic tsr_event_e win(input tsr_req_s r);
		if (r.halt) return EV_HALT;
		if (r.bus_err) return EV_BUSER;
		if (r.mmu_err) return EV_MMU;
		if (r.trap_insn) return EV_TRAPI;
		if (r.trace) return EV_TRACE;
		if (r.stack_ovf) return EV_STKOV;
		if (r.intr) return EV_INTR;
		return EV_NONE;
	endfunction : win

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test

	// main sequence
	initial begin
		logic [15:0] d;
		logic [31:0] r;
		logic        e;
		z();
		rst(12);
		// status loads from every source, console and bus first
		for (int s = 6; s > 0; s--) begin
			d = 16'($random(seed)) | 16'h0010;
			wr(tsr_psw_src_e'(s), d, (s > 4) ? (d & 16'hffef) : d);
		end
		wr(PSW_SRC_CONS, 16'h0000, 16'h0010);
		rst(2);
		wrb(PSW_SRC_RTI, 16'h0010, EV_TRACE);
		rst(2);
		wrb(PSW_SRC_RTT, 16'h0010, EV_NONE);
		bnd('0, EV_TRACE);
		rst(2);
		// each request alone, then random mixes
		for (int b = 0; b < 24; b++) begin
			r = 32'h1 << (b % 7);
			bnd(r[6:0], win(r[6:0]));
		end
		repeat (24) begin
			r = $random(seed);
			bnd(r[6:0], win(r[6:0]));
		end
		// faulting operand, mostly in autoincrement mode
		repeat (24) begin
			r = $random(seed);
			@(negedge mclk_in);
			opnd_in = '{r[4] ? MODE_AUTOINC : r[7:5], r[0], r[1], r[2]};
			{odd_err_in, nxm_err_in} = {r[3], ~r[3]};
			e = r[3] ? (r[0] | r[2]) : ((r[0] & r[1]) | r[2]);
			if (opnd_in.mode != MODE_AUTOINC) e = 1'b0;
			want(1, {15'h0000, e});
			want(2, 16'h0001);
			clr();
		end
		rst(2);
		spc(MODE_AUTOINC, 16'h00fe, 1'b0, 1'b0);
		spc(MODE_AUTODEC, 16'h0200, 1'b0, 1'b0);
		spc(MODE_AUTODEC, 16'h0100, 1'b0, 1'b0);
		spc(MODE_AUTODEC, 16'h00fe, 1'b0, 1'b1);
		rst(2);
		spc(MODE_AUTODECD, 16'h00fe, 1'b0, 1'b1);
		rst(2);
		spc(3'h0, 16'h00fe, 1'b1, 1'b1);
		bnd('0, EV_STKOV);
		spc(3'h0, 16'h0200, 1'b1, 1'b0);
		rst(2);
		// violation outside the push window, then inside it
		@(negedge mclk_in);
		{mmu_viol_in, vec_word_in} = {1'b1, 16'h1234};
		want(6, 16'h0000);
		clr();
		@(negedge mclk_in);
		push1_done_in = 1'b1;
		clr();
		@(negedge mclk_in);
		d = 16'($random(seed));
		{mmu_viol_in, vec_word_in} = {1'b1, d};
		want(5, d);
		want(6, 16'h0001);
		clr();
		@(negedge mclk_in);
		push2_done_in = 1'b1;
		want(6, 16'h0000);
		clr();
		rst(2);
		// service routine entry, then higher and lower pending interrupts
		for (int i = 0; i < 3; i++) begin
			@(negedge mclk_in);
			{isr_entry_in, req_in.intr} = {1'b1, i > 0};
			intr_prio_in = (i == 0) ? 3'h3 : ((i == 1) ? 3'h5 : 3'h2);
			if (i > 0) want(7, (i == 1) ? 16'h0001 : 16'h0000);
			clr();
		end
		repeat (3) @(negedge mclk_in);
		finish_test();
	end
endmodule : tb
